// file: eil_cpu_pin_model.sv
// Purpose: Far-side model: interrupt pin driver and CPU vector fetch
// Assumes: Pin driven low on request, else pull-up or floating
// Notes: Floating pin without pull-up toggles every cycle
`timescale 1ns/1ps
module eil_cpu_pin_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic pinLow,
  input wire logic autoAck,
  input wire logic slowAck,
  input wire logic cpuIrqReq,
  input wire logic [15:0] vectorAddr,
  input wire logic pullupEnable,
  output logic extIntPinN,
  output logic vectorFetchAck,
  output logic [7:0] fetchCount
);
  import eil_pkg::*;
  logic lastPin;
  logic [1:0] lag;
  // No keeper on the pin: an undriven, unpulled pin is not a stable level
  assign extIntPinN = pinLow ? 1'b0 : (pullupEnable ? 1'b1 : ~lastPin);
  always_ff @(posedge core_clk) begin
    lastPin <= extIntPinN;
  end
  // ----------------------------------------------------------------
  // CPU side: fetch vector high byte once the request is presented
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      vectorFetchAck <= 1'b0;
      fetchCount <= 8'h00;
      lag <= 2'h0;
    end else if (vectorFetchAck) begin
      vectorFetchAck <= 1'b0;
    end else if (autoAck && cpuIrqReq && vectorAddr === VECTOR_HI_ADDR) begin
      if (lag == (slowAck ? 2'h3 : 2'h0)) begin
        vectorFetchAck <= 1'b1;
        fetchCount <= fetchCount + 8'h01;
        lag <= 2'h0;
      end else begin
        lag <= lag + 2'h1;
      end
    end
  end
endmodule // eil_cpu_pin_model

// file: eil_external_pin_interrupt_latch.sv
// Purpose: Falling-edge / low-level external interrupt latch with AXI4-Lite registers
// Assumes: Pin asynchronous, CPU strobes synchronous; 50 MHz core_clk; sync active-low reset
// Notes: Vector request presented while unmasked; CPU fetches high byte first
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module eil_external_pin_interrupt_latch (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic extIntPinN,
  input wire logic vectorFetchAck,
  input wire logic breakState,
  output logic cpuIrqReq,
  output logic [15:0] vectorAddr,
  output logic pinLevelHigh,
  output logic pullupEnable,
  output logic evtIrq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import eil_pkg::*;

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == OFF_STATUS_CONTROL) || (a == OFF_CONFIG_TWO) || (a == OFF_BREAK_CTRL) ||
               (a == OFF_EVT_STATUS) || (a == OFF_EVT_ENABLE) || (a == OFF_EVT_CLEAR);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------------------------------
  logic pinMeta, pinSync, pinPrev;
  logic fallEdge;
  // No reset here: the stages keep tracking a pin held low through reset,
  // so release does not see a fresh falling edge
  always_ff @(posedge core_clk) begin
    pinMeta <= extIntPinN;
    pinSync <= pinMeta;
    pinPrev <= pinSync;
  end
  assign fallEdge = pinPrev && !pinSync;
  assign pinLevelHigh = pinSync;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic awHeld, wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Only the low byte lane carries register bits
  logic wrLow;
  assign wrLow = doWrite && wStrb[0];

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic senseSelect, intMask, pullupDisable, breakClearEnable;
  logic swAck;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      senseSelect <= RST_STATUS_CONTROL[BIT_SENSE];
      intMask <= RST_STATUS_CONTROL[BIT_MASK];
      pullupDisable <= RST_CONFIG_TWO[BIT_PULLUP_DIS];
      breakClearEnable <= 1'b0;
    end else if (wrLow) begin
      if (awAddr == OFF_STATUS_CONTROL) begin
        senseSelect <= wData[BIT_SENSE];
        intMask <= wData[BIT_MASK];
      end
      if (awAddr == OFF_CONFIG_TWO) begin
        pullupDisable <= wData[BIT_PULLUP_DIS];
      end
      if (awAddr == OFF_BREAK_CTRL) begin
        breakClearEnable <= wData[BIT_BREAK_CLR_EN];
      end
    end
  end
  assign pullupEnable = !pullupDisable;
  assign swAck = wrLow && (awAddr == OFF_STATUS_CONTROL) && wData[BIT_ACK];

  // ----------------------------------------------------------------
  // Request latch
  // ----------------------------------------------------------------
  logic reqLatch, ackSeen, effAck, next_reqLatch, next_ackSeen;
  assign effAck = vectorFetchAck || (swAck && (!breakState || breakClearEnable));
  always_comb begin
    next_reqLatch = reqLatch;
    next_ackSeen = ackSeen;
    if (!senseSelect) begin
      next_ackSeen = 1'b0;
      if (effAck) next_reqLatch = 1'b0;
    end else begin
      if (effAck && reqLatch) next_ackSeen = 1'b1;
      // Both ack and pin-high needed, either order
      if ((effAck || ackSeen) && pinSync) begin
        next_reqLatch = 1'b0;
        next_ackSeen = 1'b0;
      end
    end
    // New edge wins over a clear in the same cycle
    if (fallEdge) begin
      next_reqLatch = 1'b1;
      next_ackSeen = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reqLatch <= 1'b0;
      ackSeen <= 1'b0;
    end else begin
      reqLatch <= next_reqLatch;
      ackSeen <= next_ackSeen;
    end
  end
  logic pending;
  // Level mode holds the request while the pin is low
  assign pending = reqLatch || (senseSelect && reqLatch && !pinSync);
  assign cpuIrqReq = pending && !intMask;
  always_ff @(posedge core_clk) begin
    if (!nrst) vectorAddr <= 16'h0000;
    else vectorAddr <= (pending && !intMask) ? VECTOR_HI_ADDR : 16'h0000;
  end

  // ----------------------------------------------------------------
  // Event status, enable, clear
  // ----------------------------------------------------------------
  logic [1:0] evtStatus, evtEnable, evtSet, evtClr;
  assign evtSet = {swAck, fallEdge};
  assign evtClr = (wrLow && awAddr == OFF_EVT_CLEAR) ? wData[1:0] : 2'b00;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      evtStatus <= 2'b00;
      evtEnable <= 2'b00;
    end else begin
      evtStatus <= (evtStatus & ~evtClr) | evtSet;
      if (wrLow && awAddr == OFF_EVT_ENABLE) evtEnable <= wData[1:0];
    end
  end
  assign evtIrq = |(evtStatus & evtEnable);

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    unique case (s_axi_araddr)
      OFF_STATUS_CONTROL: begin
        rdByte[BIT_SENSE] = senseSelect;
        rdByte[BIT_MASK] = intMask;
        rdByte[BIT_ACK] = 1'b0;
        rdByte[BIT_PENDING] = pending;
      end
      OFF_CONFIG_TWO: rdByte[BIT_PULLUP_DIS] = pullupDisable;
      OFF_BREAK_CTRL: rdByte[BIT_BREAK_CLR_EN] = breakClearEnable;
      OFF_EVT_STATUS: rdByte[1:0] = evtStatus;
      OFF_EVT_ENABLE: rdByte[1:0] = evtEnable;
      default: rdByte = 8'h00;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h0, rdByte};
      s_axi_rresp <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_edge_sets_latch: assert property (fallEdge |=> reqLatch) else $error("edge lost");
  a_mask_gates_req: assert property (intMask |-> !cpuIrqReq) else $error("masked request seen");
  a_level_holds: assert property (senseSelect && reqLatch && !pinSync && !fallEdge |=> reqLatch)
    else $error("level request dropped");
  a_edge_mode_clear: assert property (!senseSelect && vectorFetchAck && !fallEdge |=> !reqLatch)
    else $error("edge mode not cleared");
  a_level_pair_clear: assert property (senseSelect && vectorFetchAck && reqLatch && pinSync && !fallEdge
    |=> !reqLatch) else $error("level clear missed");
  a_break_protect: assert property (breakState && !breakClearEnable && swAck && !vectorFetchAck
    && !senseSelect && !fallEdge |=> reqLatch == $past(reqLatch)) else $error("break ack changed latch");
  a_pending_poll: assert property (reqLatch |-> ##1 (s_axi_rdata[BIT_PENDING] || !$past(s_axi_arvalid)
    || $past(s_axi_araddr) != OFF_STATUS_CONTROL || !$past(s_axi_arready))) else $error("flag wrong");
  a_ack_reads_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[BIT_ACK]) else $error("ack read one");
  a_pullup_follows: assert property (wrLow && awAddr == OFF_CONFIG_TWO
    |=> pullupEnable == !$past(wData[BIT_PULLUP_DIS]))
    else $error("pullup wrong");

  // ----------------------------------------------------------------
  // Checks: reset and pin path
  // ----------------------------------------------------------------
  // Reset is the one time this must hold, so the default disable is overridden
  a_reset_clears: assert property (disable iff (1'b0) !nrst
    |=> !reqLatch && !senseSelect && !intMask)
    else $error("reset left state");
  a_pin_two_stage: assert property (pinLevelHigh == $past(extIntPinN, 2))
    else $error("pin level stale");
  a_edge_after_ack: assert property (effAck && fallEdge |=> reqLatch)
    else $error("edge after ack lost");

  // ----------------------------------------------------------------
  // Checks: mask, vector and control bits
  // ----------------------------------------------------------------
  a_unmasked_passes: assert property (reqLatch && !intMask |-> cpuIrqReq)
    else $error("unmasked request held back");
  a_idle_no_req: assert property (!reqLatch |-> !cpuIrqReq)
    else $error("request without latch");
  a_masked_kept: assert property (intMask && reqLatch && !effAck && !ackSeen |=> reqLatch)
    else $error("masked request dropped");
  a_vector_shown: assert property (cpuIrqReq |=> vectorAddr == VECTOR_HI_ADDR)
    else $error("vector not presented");
  a_vector_idle: assert property (!cpuIrqReq |=> vectorAddr == 16'h0000)
    else $error("vector shown while idle");
  a_mask_write: assert property (wrLow && awAddr == OFF_STATUS_CONTROL
    |=> intMask == $past(wData[BIT_MASK]))
    else $error("mask write lost");
  a_sense_write: assert property (wrLow && awAddr == OFF_STATUS_CONTROL
    |=> senseSelect == $past(wData[BIT_SENSE]))
    else $error("sense write lost");
  a_pending_flag: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_STATUS_CONTROL
    |=> s_axi_rdata[BIT_PENDING] == $past(reqLatch))
    else $error("pending flag wrong");

  // ----------------------------------------------------------------
  // Checks: acknowledge paths
  // ----------------------------------------------------------------
  a_sw_ack_clear: assert property (!senseSelect && swAck && !breakState && !fallEdge
    |=> !reqLatch)
    else $error("software ack ignored");
  a_edge_no_memory: assert property (!senseSelect |=> !ackSeen)
    else $error("edge mode kept ack");
  a_level_ack_kept: assert property (senseSelect && effAck && reqLatch && !pinSync && !fallEdge
    |=> ackSeen && reqLatch)
    else $error("level ack not recorded");
  a_level_pin_high: assert property (senseSelect && ackSeen && pinSync && !fallEdge
    |=> !reqLatch)
    else $error("level clear after pin high missed");
  a_break_clear: assert property (breakState && breakClearEnable && swAck && !senseSelect && !fallEdge
    |=> !reqLatch)
    else $error("break ack did not clear");
  // Long low periods after an ack: counted here rather than unrolled in a property
  logic [3:0] lowAfterAck;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      lowAfterAck <= 4'h0;
    end else if (senseSelect && ackSeen && !pinSync) begin
      if (lowAfterAck != 4'hf) lowAfterAck <= lowAfterAck + 4'h1;
    end else begin
      lowAfterAck <= 4'h0;
    end
  end
  a_level_after_ack: assert property (lowAfterAck != 4'h0 |-> reqLatch)
    else $error("request dropped while pin low");

  // ----------------------------------------------------------------
  // Checks: bus and event registers
  // ----------------------------------------------------------------
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && !isMapped(s_axi_araddr)
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read accepted");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  // Set beats a clear landing in the same cycle
  a_evt_set_wins: assert property (fallEdge |=> evtStatus[BIT_EVT_LATCH])
    else $error("edge event lost");
  a_evt_clear: assert property (wrLow && awAddr == OFF_EVT_CLEAR && !fallEdge
    |=> (evtStatus & $past(wData[1:0])) == 2'b00)
    else $error("event clear ignored");
  c_edge_req: cover property (fallEdge ##1 cpuIrqReq);
  c_level_wait: cover property (senseSelect && effAck && !pinSync ##[1:20] !reqLatch);
  c_break_ack: cover property (breakState && swAck);
  c_fetch_clear: cover property (vectorFetchAck ##1 !reqLatch);
  c_level_pair: cover property (senseSelect && ackSeen && pinSync ##1 !reqLatch);
endmodule // eil_external_pin_interrupt_latch

// file: eil_pkg.sv
// Purpose: Shared constants for the external pin interrupt latch
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: Register fields sit in the low byte; upper bits read zero
package eil_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
  // Printed offset is not word aligned: kept as an index, one word per index
  localparam logic [7:0] IDX_CONFIG_TWO = 8'h1e;
  localparam logic [7:0] OFF_CONFIG_TWO = {IDX_CONFIG_TWO[5:0], 2'b00};
  localparam logic [7:0] OFF_BREAK_CTRL = 8'h20;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h24;
  localparam logic [7:0] OFF_EVT_ENABLE = 8'h28;
  localparam logic [7:0] OFF_EVT_CLEAR = 8'h2c;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_SENSE = 0;
  localparam int BIT_MASK = 1;
  localparam int BIT_ACK = 2;
  localparam int BIT_PENDING = 3;
  localparam int BIT_PULLUP_DIS = 0;
  localparam int BIT_BREAK_CLR_EN = 0;
  localparam int BIT_EVT_LATCH = 0;
  localparam int BIT_EVT_ACK = 1;
  // ----------------------------------------------------------------
  // Reset values and vector
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] RST_CONFIG_TWO = 8'h00;
  localparam logic [15:0] VECTOR_HI_ADDR = 16'hfffa;
  localparam logic [15:0] VECTOR_LO_ADDR = 16'hfffb;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: testbench.sv
// Purpose: Self-checking bench for the external pin interrupt latch
// Assumes: AXI4-Lite master tasks, bready and rready held high
// Notes: Pin changes are given six edges to pass the synchroniser
`timescale 1ns/1ps
module testbench;
  import eil_pkg::*;
  logic core_clk = 0, nrst = 0, pinLow = 0, autoAck = 0, slowAck = 0, breakState = 0;
  logic extIntPinN, vectorFetchAck, cpuIrqReq, pinLevelHigh, pullupEnable, evtIrq;
  logic [15:0] vectorAddr;
  logic [7:0] fetchCount, awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, arvalid = 0, awready, wready, arready, bvalid, rvalid;
  logic [1:0] bresp, rresp;
  int bad_count = 0, checks_done = 0;
  always #10 core_clk = ~core_clk;
  eil_cpu_pin_model partner (.core_clk(core_clk), .nrst(nrst), .pinLow(pinLow), .autoAck(autoAck),
    .slowAck(slowAck), .cpuIrqReq(cpuIrqReq), .vectorAddr(vectorAddr), .pullupEnable(pullupEnable),
    .extIntPinN(extIntPinN), .vectorFetchAck(vectorFetchAck), .fetchCount(fetchCount));
  eil_external_pin_interrupt_latch dut (.core_clk(core_clk), .nrst(nrst), .extIntPinN(extIntPinN),
    .vectorFetchAck(vectorFetchAck), .breakState(breakState), .cpuIrqReq(cpuIrqReq),
    .vectorAddr(vectorAddr), .pinLevelHigh(pinLevelHigh), .pullupEnable(pullupEnable), .evtIrq(evtIrq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1));
  task automatic close_out;
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic timed_out;
    bad_count++;
    $display("BAD %0t bus wait ran out", $time);
    close_out();
  endtask
  // ----------------------------------------------------------------
  // Bus tasks: readies sampled at the falling edge, acted on at rising
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w, b;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge core_clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge core_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) break;
    end
    if (n == 50) timed_out();
    chk(r, RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    int n;
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge core_clk);
      ar = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (ar) arvalid <= 1'b0;
      if (v) break;
    end
    if (n == 50) timed_out();
    chk(d, e);
    chk(r, er);
  endtask
  task automatic pin(input logic v);
    pinLow <= v;
    repeat (6) @(posedge core_clk);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd(OFF_STATUS_CONTROL, {24'h0, RST_STATUS_CONTROL});
    rd(OFF_CONFIG_TWO, {24'h0, RST_CONFIG_TWO});
    chk(pullupEnable, 1'b1);
    wr(OFF_EVT_ENABLE, 32'h3);
    pin(1'b1);
    chk(pinLevelHigh, 1'b0);
    rd(OFF_STATUS_CONTROL, 32'h08);
    chk(cpuIrqReq, 1'b1);
    chk(vectorAddr, {16'h0, VECTOR_HI_ADDR});
    chk(evtIrq, 1'b1);
    wr(OFF_STATUS_CONTROL, 32'h02);
    rd(OFF_STATUS_CONTROL, 32'h0a);
    chk(cpuIrqReq, 1'b0);
    chk(vectorAddr, 32'h0);
    wr(OFF_STATUS_CONTROL, 32'h06);
    rd(OFF_STATUS_CONTROL, 32'h02);
    pin(1'b0);
    chk(pinLevelHigh, 1'b1);
    rd(OFF_EVT_STATUS, 32'h3);
    wr(OFF_EVT_CLEAR, 32'h3);
    chk(evtIrq, 1'b0);
    rd(OFF_EVT_STATUS, 32'h0);
    wr(OFF_EVT_ENABLE, 32'h0);
    pin(1'b1);
    rd(OFF_STATUS_CONTROL, 32'h0a);
    chk(evtIrq, 1'b0);
    wr(OFF_STATUS_CONTROL, 32'h04);
    rd(OFF_STATUS_CONTROL, 32'h00);
    pin(1'b0);
    autoAck <= 1'b1;
    slowAck <= 1'b1;
    pin(1'b1);
    // Fetch lag belongs to the model; wait for it, but not forever
    for (int k = 0; k < 20 && fetchCount == 8'h00; k++) @(posedge core_clk);
    chk(fetchCount, 8'h01);
    rd(OFF_STATUS_CONTROL, 32'h00);
    autoAck <= 1'b0;
    pin(1'b0);
    wr(OFF_STATUS_CONTROL, 32'h01);
    pin(1'b1);
    wr(OFF_STATUS_CONTROL, 32'h05);
    rd(OFF_STATUS_CONTROL, 32'h09);
    chk(cpuIrqReq, 1'b1);
    wr(OFF_STATUS_CONTROL, 32'h03);
    rd(OFF_STATUS_CONTROL, 32'h0b);
    chk(cpuIrqReq, 1'b0);
    pin(1'b0);
    rd(OFF_STATUS_CONTROL, 32'h03);
    wr(OFF_STATUS_CONTROL, 32'h01);
    pin(1'b1);
    pin(1'b0);
    rd(OFF_STATUS_CONTROL, 32'h09);
    wr(OFF_STATUS_CONTROL, 32'h05);
    rd(OFF_STATUS_CONTROL, 32'h01);
    pin(1'b1);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    pin(1'b1);
    rd(OFF_STATUS_CONTROL, 32'h00);
    pin(1'b0);
    pin(1'b1);
    breakState <= 1'b1;
    wr(OFF_STATUS_CONTROL, 32'h04);
    rd(OFF_STATUS_CONTROL, 32'h08);
    wr(OFF_BREAK_CTRL, 32'h1);
    wr(OFF_STATUS_CONTROL, 32'h04);
    breakState <= 1'b0;
    pin(1'b0);
    rd(OFF_STATUS_CONTROL, 32'h00);
    pinLow <= 1'b1;
    wr(OFF_CONFIG_TWO, 32'h1);
    chk(pullupEnable, 1'b0);
    rd(OFF_CONFIG_TWO, 32'h1);
    rd(8'h40, 32'h0, RESP_SLVERR);
    close_out();
  end
endmodule // testbench
